// ---- src/dgp_pkg.sv ----
`default_nettype none
package dgp_pkg;
    // ========================================
    // Register offsets
    localparam logic [7:0] THIRD_PORT_DATA_OFS = 8'h07;
    localparam logic [7:0] FOURTH_PORT_DATA_OFS = 8'h08;
    localparam logic [7:0] THIRD_PORT_DIRECTION_OFS = 8'h87;
    localparam logic [7:0] FOURTH_PORT_DIRECTION_OFS = 8'h88;
    localparam logic [7:0] FIFTH_PORT_CONTROL_OFS = 8'h89;

    // ========================================
    // Reset values
    localparam logic [7:0] DIRECTION_RST = 8'hFF;
    localparam logic [2:0] FIFTH_DIR_RST = 3'h7;
    localparam logic MODE_RST = 1'h0;
    // Latches are undefined at power-on; this is the value we happen to load
    localparam logic [7:0] LATCH_POR = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // ========================================
    // Fifth port control field positions
    localparam int CTL_IN_FULL_BIT = 7;
    localparam int CTL_OUT_FULL_BIT = 6;
    localparam int CTL_IN_OVERFLOW_BIT = 5;
    localparam int CTL_MODE_BIT = 4;
    localparam int CTL_DIR_MSB = 2;

    // ========================================
    // Third port pin functions
    localparam int PC_TIMER_OSC_CLK = 0;
    localparam int PC_TIMER_OSC_CAPTURE2 = 1;
    localparam int PC_CAPTURE1 = 2;
    localparam int PC_SERIAL_CLK = 3;
    localparam int PC_SERIAL_DIN = 4;
    localparam int PC_SERIAL_DOUT = 5;
    localparam int PC_USART_TX_CK = 6;
    localparam int PC_USART_RX_DT = 7;

    // ========================================
    // Carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dgp_reg_req_t;

    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] out;
        logic [7:0] oe;
    } dgp_periph_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dgp_pin_drive_t;

    typedef struct packed {
        logic input_buffer_full_flag;
        logic output_buffer_full_flag;
        logic input_overflow_flag;
    } dgp_slave_flags_t;
endpackage : dgp_pkg
`default_nettype wire

// ---- src/dgp_port.sv ----
`default_nettype none
module dgp_port
    import dgp_pkg::*;
(
    input wire logic clk, // Core clock, 20 MHz
    input wire logic nrst, // Power-on / brown-out reset
    input wire logic other_rst, // Any other reset, synchronous pulse
    input wire dgp_reg_req_t req, // CPU register access
    output var logic [7:0] rd_data, // Read data, one cycle after rd
    input wire logic [7:0] third_pin_in, // Third port pin levels
    output var dgp_pin_drive_t third_pin, // Third port driver and enable
    input wire logic [7:0] fourth_pin_in, // Fourth port pin levels
    output var dgp_pin_drive_t fourth_pin, // Fourth port driver and enable
    input wire dgp_periph_t third_periph, // Peripheral claims on third port
    output var logic [7:0] third_periph_in, // Synced third pins to peripherals
    input wire logic [7:0] slave_bus_out, // Slave port data to drive
    input wire logic slave_bus_oe, // Slave port drives bus
    input wire dgp_slave_flags_t slave_flags, // Slave port status flags
    output var logic [7:0] slave_bus_in, // Synced fourth pins to slave port
    output var logic slave_port_mode_select, // Slave port mode active
    output var logic [2:0] fifth_port_dir // Fifth port direction bits
);

    // ========================================
    // State
    typedef struct packed {
        logic [7:0] third_port_data;
        logic [7:0] fourth_port_data;
        logic [7:0] third_port_direction;
        logic [7:0] fourth_port_direction;
        logic mode;
        logic [2:0] fifth_dir;
        logic [7:0] c_meta;
        logic [7:0] c_sync;
        logic [7:0] d_meta;
        logic [7:0] d_sync;
        logic [7:0] rd_data;
        dgp_pin_drive_t c_drv;
        dgp_pin_drive_t d_drv;
    } dgp_state_t;

    localparam dgp_state_t STATE_RST = '{
        third_port_data: LATCH_POR,
        fourth_port_data: LATCH_POR,
        third_port_direction: DIRECTION_RST,
        fourth_port_direction: DIRECTION_RST,
        mode: MODE_RST,
        fifth_dir: FIFTH_DIR_RST,
        c_meta: DATA_RST,
        c_sync: DATA_RST,
        d_meta: DATA_RST,
        d_sync: DATA_RST,
        rd_data: DATA_RST,
        c_drv: '{out: DATA_RST, oe: DATA_RST},
        d_drv: '{out: DATA_RST, oe: DATA_RST}
    };

    dgp_state_t st;
    dgp_state_t next_st;

    // ========================================
    // One pin: the select feeds the driver from peripheral or latch
    function automatic logic [1:0] lane(
        input logic sel,
        input logic alt_out,
        input logic alt_oe,
        input logic latch,
        input logic dir
    );
        logic [1:0] v;
        v[1] = sel ? alt_out : latch;
        v[0] = sel ? alt_oe : ~dir;
        return v;
    endfunction : lane

    // Third port lane i: its peripheral claims it through sel
    function automatic logic [1:0] third_lane(
        input int i,
        input dgp_periph_t p,
        input logic [7:0] latch,
        input logic [7:0] dir
    );
        return lane(p.sel[i], p.out[i], p.oe[i], latch[i], dir[i]);
    endfunction : third_lane

    // Fourth port lane i: slave mode hands the pin to bus bit i
    function automatic logic [1:0] fourth_lane(
        input int i,
        input logic mode,
        input logic [7:0] bus,
        input logic bus_oe,
        input logic [7:0] latch,
        input logic [7:0] dir
    );
        return lane(mode, bus[i], bus_oe, latch[i], dir[i]);
    endfunction : fourth_lane

    // ========================================
    // Control register as software reads it; bit 3 is always zero
    function automatic logic [7:0] ctl_image(
        input dgp_slave_flags_t f,
        input logic mode,
        input logic [2:0] dir
    );
        logic [7:0] v;
        v = DATA_RST;
        v[CTL_IN_FULL_BIT] = f.input_buffer_full_flag;
        v[CTL_OUT_FULL_BIT] = f.output_buffer_full_flag;
        v[CTL_IN_OVERFLOW_BIT] = f.input_overflow_flag;
        v[CTL_MODE_BIT] = mode;
        v[CTL_DIR_MSB:0] = dir;
        return v;
    endfunction : ctl_image

    function automatic logic hit(input dgp_reg_req_t r, input logic [7:0] ofs);
        return r.addr == ofs;
    endfunction : hit

    // ========================================
    // Next state
    always_comb begin
        logic [7:0][1:0] c_lane;
        logic [7:0][1:0] d_lane;
        dgp_periph_t cp;
        logic [7:0] cl;
        logic [7:0] cd;
        logic [7:0] dl;
        logic [7:0] dd;
        c_lane = '0;
        d_lane = '0;
        cp = third_periph;
        cl = st.third_port_data;
        cd = st.third_port_direction;
        dl = st.fourth_port_data;
        dd = st.fourth_port_direction;
        next_st = st;

        // Two-stage synchronisers on pin levels
        next_st.c_meta = third_pin_in;
        next_st.c_sync = st.c_meta;
        next_st.d_meta = fourth_pin_in;
        next_st.d_sync = st.d_meta;

        // Register writes; latches written whatever the direction
        if (req.wr) begin
            if (hit(req, THIRD_PORT_DATA_OFS)) begin
                next_st.third_port_data = req.wdata;
            end
            if (hit(req, FOURTH_PORT_DATA_OFS)) begin
                next_st.fourth_port_data = req.wdata;
            end
            if (hit(req, THIRD_PORT_DIRECTION_OFS)) begin
                next_st.third_port_direction = req.wdata;
            end
            if (hit(req, FOURTH_PORT_DIRECTION_OFS)) begin
                next_st.fourth_port_direction = req.wdata;
            end
            if (hit(req, FIFTH_PORT_CONTROL_OFS)) begin
                next_st.mode = req.wdata[CTL_MODE_BIT];
                next_st.fifth_dir = req.wdata[CTL_DIR_MSB:0];
            end
        end

        // Other resets restore configuration but keep the latches
        if (other_rst) begin
            next_st.third_port_direction = DIRECTION_RST;
            next_st.fourth_port_direction = DIRECTION_RST;
            next_st.mode = MODE_RST;
            next_st.fifth_dir = FIFTH_DIR_RST;
            next_st.third_port_data = st.third_port_data;
            next_st.fourth_port_data = st.fourth_port_data;
        end

        // Register reads; unmapped addresses and unused bits give zero
        if (req.rd) begin
            unique case (1'b1)
                hit(req, THIRD_PORT_DATA_OFS): next_st.rd_data = st.c_sync;
                hit(req, FOURTH_PORT_DATA_OFS): next_st.rd_data = st.d_sync;
                hit(req, THIRD_PORT_DIRECTION_OFS): next_st.rd_data = st.third_port_direction;
                hit(req, FOURTH_PORT_DIRECTION_OFS): next_st.rd_data = st.fourth_port_direction;
                hit(req, FIFTH_PORT_CONTROL_OFS): begin
                    next_st.rd_data = ctl_image(slave_flags, st.mode, st.fifth_dir);
                end
                default: next_st.rd_data = DATA_RST;
            endcase
        end

        // Third port lanes and the peripheral functions they carry
        c_lane[PC_TIMER_OSC_CLK] = third_lane(PC_TIMER_OSC_CLK, cp, cl, cd);
        c_lane[PC_TIMER_OSC_CAPTURE2] = third_lane(PC_TIMER_OSC_CAPTURE2, cp, cl, cd);
        c_lane[PC_CAPTURE1] = third_lane(PC_CAPTURE1, cp, cl, cd);
        c_lane[PC_SERIAL_CLK] = third_lane(PC_SERIAL_CLK, cp, cl, cd);
        c_lane[PC_SERIAL_DIN] = third_lane(PC_SERIAL_DIN, cp, cl, cd);
        c_lane[PC_SERIAL_DOUT] = third_lane(PC_SERIAL_DOUT, cp, cl, cd);
        c_lane[PC_USART_TX_CK] = third_lane(PC_USART_TX_CK, cp, cl, cd);
        c_lane[PC_USART_RX_DT] = third_lane(PC_USART_RX_DT, cp, cl, cd);
        for (int i = 0; i < 8; i++) begin
            next_st.c_drv.out[i] = c_lane[i][1];
            next_st.c_drv.oe[i] = c_lane[i][0];
        end

        // Fourth port lanes; slave mode overrides latch and direction
        d_lane[0] = fourth_lane(0, st.mode, slave_bus_out, slave_bus_oe, dl, dd);
        d_lane[1] = fourth_lane(1, st.mode, slave_bus_out, slave_bus_oe, dl, dd);
        d_lane[2] = fourth_lane(2, st.mode, slave_bus_out, slave_bus_oe, dl, dd);
        d_lane[3] = fourth_lane(3, st.mode, slave_bus_out, slave_bus_oe, dl, dd);
        d_lane[4] = fourth_lane(4, st.mode, slave_bus_out, slave_bus_oe, dl, dd);
        d_lane[5] = fourth_lane(5, st.mode, slave_bus_out, slave_bus_oe, dl, dd);
        d_lane[6] = fourth_lane(6, st.mode, slave_bus_out, slave_bus_oe, dl, dd);
        d_lane[7] = fourth_lane(7, st.mode, slave_bus_out, slave_bus_oe, dl, dd);
        for (int i = 0; i < 8; i++) begin
            next_st.d_drv.out[i] = d_lane[i][1];
            next_st.d_drv.oe[i] = d_lane[i][0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // Outputs
    always_comb begin
        rd_data = st.rd_data;
        third_pin = st.c_drv;
        fourth_pin = st.d_drv;
        third_periph_in = st.c_sync;
        slave_bus_in = st.d_sync;
        slave_port_mode_select = st.mode;
        fifth_port_dir = st.fifth_dir;
    end

endmodule : dgp_port
`default_nettype wire

// ---- tb/dgp_pin_model.sv ----
`default_nettype none
module dgp_pin_model
    import dgp_pkg::*;
(
    input wire logic clk, // Clock
    input wire dgp_pin_drive_t drv, // Device drive
    input wire logic [7:0] ext, // Outside value
    input wire logic [7:0] ext_oe, // Outside enable
    output logic [7:0] level // Pin level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wander = 8'h00;
    // Floating pins toggle so a stale value never reads back
    always @(posedge clk) wander <= ~wander;
    assign level = (drv.oe & drv.out) | (~drv.oe & ((ext_oe & ext) | (~ext_oe & wander)));
endmodule : dgp_pin_model
`default_nettype wire

// ---- tb/dgp_port_sva.sv ----
`default_nettype none
module dgp_port_sva
    import dgp_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic nrst, // Reset
    input wire logic other_rst, // Sync reset
    input wire dgp_reg_req_t req, // Access
    input wire logic [7:0] rd_data, // Read data
    input wire dgp_pin_drive_t third_pin, // Drive
    input wire dgp_pin_drive_t fourth_pin, // Drive
    input wire dgp_periph_t third_periph, // Claims
    input wire logic [7:0] slave_bus_out, // Slave data
    input wire logic slave_bus_oe, // Slave drive
    input wire logic slave_port_mode_select, // Mode
    input wire logic [2:0] fifth_port_dir // Fifth dir
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic ctl;
    logic mapped;
    assign ctl = req.addr == FIFTH_PORT_CONTROL_OFS;
    assign mapped = req.addr inside {8'h07, 8'h08, 8'h87, 8'h88, 8'h89};
    a_sel_out: assert property (!other_rst |=> ((third_pin.out ^ $past(third_periph.out))
        & $past(third_periph.sel)) == 8'h00) else $error("peripheral output not routed");
    a_sel_oe: assert property (!other_rst |=> ((third_pin.oe ^ $past(third_periph.oe))
        & $past(third_periph.sel)) == 8'h00) else $error("peripheral enable not routed");
    a_slave_drive: assert property (slave_port_mode_select && !other_rst |=>
        fourth_pin.out == $past(slave_bus_out) && fourth_pin.oe == {8{$past(slave_bus_oe)}})
        else $error("slave bus drive wrong");
    a_mode_write: assert property (req.wr && ctl && !other_rst |=>
        slave_port_mode_select == $past(req.wdata[4])) else $error("mode bit not written");
    a_soft_reset: assert property (other_rst |=>
        !slave_port_mode_select && fifth_port_dir == 3'h7) else $error("soft reset values");
    a_unmapped_zero: assert property (req.rd && !mapped |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_ctl_read: assert property (req.rd && ctl |=> rd_data[4:0] ==
        {$past(slave_port_mode_select), 1'h0, $past(fifth_port_dir)}) else $error("ctl read");
    a_rd_hold: assert property (!req.rd && !other_rst |=> $stable(rd_data))
        else $error("read data moved");
    c_mode: cover property (req.wr && ctl && req.wdata[4]);
    c_sel: cover property (third_periph.sel != 8'h00);
    c_unmapped: cover property (req.rd && !mapped);
endmodule : dgp_port_sva
bind dgp_port dgp_port_sva dgp_port_sva_inst (.clk, .nrst, .other_rst, .req, .rd_data,
    .third_pin, .fourth_pin, .third_periph, .slave_bus_out, .slave_bus_oe,
    .slave_port_mode_select, .fifth_port_dir);
`default_nettype wire

// ---- tb/tb_dgp_port.sv ----
`default_nettype none
module tb_dgp_port
    import dgp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, nrst = 1'h0, other_rst = 1'h0, slave_bus_oe = 1'h0, rd_seen = 1'h0;
    dgp_reg_req_t req = 18'h0;
    dgp_periph_t third_periph = 24'h0;
    dgp_slave_flags_t slave_flags = 3'h0;
    logic [7:0] slave_bus_out = 8'h00, ext3 = 8'h00, ext4 = 8'h00, ext_oe = 8'hFF;
    logic [7:0] rd_data, third_pin_in, fourth_pin_in, d, v, tpi, sbi;
    dgp_pin_drive_t third_pin, fourth_pin;
    int seed = 32'h9bc7, fail_count = 0, comparisons = 0, cycles = 0;
    logic [7:0] exp_q[$];
    dgp_port dgp_port_inst (.clk, .nrst, .other_rst, .req, .rd_data, .third_pin_in, .third_pin,
        .fourth_pin_in, .fourth_pin, .third_periph, .third_periph_in(tpi), .slave_bus_out,
        .slave_bus_oe, .slave_flags, .slave_bus_in(sbi), .slave_port_mode_select(),
        .fifth_port_dir());
    dgp_pin_model pins3 (.clk, .drv(third_pin), .ext(ext3), .ext_oe, .level(third_pin_in));
    dgp_pin_model pins4 (.clk, .drv(fourth_pin), .ext(ext4), .ext_oe, .level(fourth_pin_in));
    initial forever #25 clk = ~clk;
    task automatic tally_and_finish;
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] x);
        req.addr = a;
        req.wdata = x;
        req.wr = w;
        req.rd = !w;
        if (!w) exp_q.push_back(x);
        idle(1);
        req = 18'h0;
        idle(1);
    endtask : acc
    always @(posedge clk) rd_seen <= req.rd;
    always @(negedge clk) if (rd_seen) cmp(rd_data, exp_q.pop_front());
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        idle(16);
        nrst = 1'h1;
        idle(1);
        acc(0, THIRD_PORT_DIRECTION_OFS, 8'hFF);
        acc(0, FOURTH_PORT_DIRECTION_OFS, 8'hFF);
        acc(0, FIFTH_PORT_CONTROL_OFS, 8'h07);
        acc(1, 8'h09, 8'hFF);
        acc(0, 8'h09, 8'h00);
        acc(1, THIRD_PORT_DATA_OFS, 8'h00);
        for (int i = 0; i < 8; i++) begin
            third_periph = {8'h01 << i, 8'($random(seed)), 8'($random(seed))};
            idle(4);
            cmp(third_pin.out, third_periph.sel & third_periph.out);
            cmp(third_pin.oe, third_periph.sel & third_periph.oe);
            cmp(tpi, third_periph.sel & third_periph.out & third_periph.oe);
        end
        repeat (4) begin
            d = 8'($random(seed));
            v = 8'($random(seed));
            ext4 = 8'($random(seed));
            acc(1, FOURTH_PORT_DATA_OFS, v);
            acc(1, FOURTH_PORT_DIRECTION_OFS, d);
            idle(3);
            cmp(fourth_pin.oe, ~d);
            acc(0, FOURTH_PORT_DIRECTION_OFS, d);
            acc(0, FOURTH_PORT_DATA_OFS, (v & ~d) | (ext4 & d));
            cmp(sbi, (v & ~d) | (ext4 & d));
        end
        slave_flags = 3'($random(seed));
        slave_bus_out = 8'($random(seed));
        slave_bus_oe = 1'h1;
        acc(1, FIFTH_PORT_CONTROL_OFS, 8'hF7);
        idle(1);
        cmp(fourth_pin.out, slave_bus_out);
        cmp(fourth_pin.oe, 8'hFF);
        acc(0, FIFTH_PORT_CONTROL_OFS, {slave_flags, 5'h17});
        slave_flags = 3'h0;
        acc(1, FOURTH_PORT_DATA_OFS, 8'h5A);
        other_rst = 1'h1;
        idle(1);
        other_rst = 1'h0;
        acc(0, FOURTH_PORT_DIRECTION_OFS, 8'hFF);
        acc(0, FIFTH_PORT_CONTROL_OFS, 8'h07);
        acc(1, FOURTH_PORT_DIRECTION_OFS, 8'h00);
        idle(3);
        acc(0, FOURTH_PORT_DATA_OFS, 8'h5A);
        idle(2);
        tally_and_finish();
    end
endmodule : tb_dgp_port
`default_nettype wire
